// file: src/wdt_pkg.sv
// Package: watchdog constants, register map and carrier types
package wdt_pkg;

  // Timing: low-power RC tick derived from the 25 MHz system clock
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned RC_HZ           = 32_000;
  localparam int unsigned RC_DIV          = CLK_HZ / RC_HZ;     // 781 cycles per tick
  localparam int unsigned BASE_MS_PRE32   = 1;                  // Nominal base period, ms
  localparam int unsigned BASE_MS_PRE128  = 4;
  localparam int unsigned PRE_DIV_32      = RC_HZ * BASE_MS_PRE32 / 1000;   // 32
  localparam int unsigned PRE_DIV_128     = RC_HZ * BASE_MS_PRE128 / 1000;  // 128

  // Configuration word field positions
  localparam int unsigned CFG_POST_LSB    = 0;
  localparam int unsigned CFG_PRE_BIT     = 4;
  localparam int unsigned CFG_WIN_BIT     = 6;
  localparam int unsigned CFG_HARD_BIT    = 7;
  localparam logic [7:0]  CFG_RESET       = 8'h00df;

  // Register byte offsets
  localparam logic [3:0]  OFS_RESET_CTRL  = 4'h0;
  localparam logic [3:0]  OFS_CONFIG      = 4'h4;
  localparam logic [3:0]  OFS_STATUS      = 4'h8;

  // Reset control register bits
  localparam int unsigned RC_IDLE_BIT     = 2;
  localparam int unsigned RC_SLEEP_BIT    = 3;
  localparam int unsigned RC_TIMEOUT_BIT  = 4;
  localparam int unsigned RC_SOFT_EN_BIT  = 5;

  // Core event strobes from the CPU and clock logic
  typedef struct packed {
    logic clear_instr;
    logic enter_sleep;
    logic enter_idle;
    logic exit_power_save;
    logic clock_switch_done;
  } wdt_events_t;

  // Watchdog outcome towards the core
  typedef struct packed {
    logic device_reset;
    logic wake;
  } wdt_result_t;

  typedef enum logic [2:0] {
    WDT_RUN   = 3'b001,
    WDT_SLEEP = 3'b010,
    WDT_IDLE  = 3'b100
  } wdt_mode_t;

endpackage

// file: src/wdt_top.sv
// Watchdog timer with prescaler, postscaler, window mode and register slave
// Summary of operation
// - Watchdog ticks from RC clock, enabled together.
// - Prescaler divides by 32 or 128.
// - Base period 1 ms or 4 ms.
// - Four-bit postscaler gives sixteen ratios up to 32768.
// - Device reset or clock switch clears counters.
// - Power-save entry, exit, clear instruction clear counters.
// - Counting continues in sleep and idle.
// - Timeout in power save wakes, no reset.
// - Hard enable keeps watchdog always on.
// - Otherwise soft enable bit 5 controls it.
// - Device reset clears soft enable bit.
// - Early clear in window mode resets device, in run mode only.
// - Timeout flag bit 4 sticky, software clears.
// - Prescale bit one is 128, zero is 32.
// - Code 1111 is 32768, each step halves.
// - Window bit one disables window operation.
//
// Usage notes
// The RC clock is modelled as a tick enable from a divider of the
// system clock, so all logic stays in one clock domain.
// The tick divider restarts with the counters, so a timeout lands a
// fixed number of cycles after the last clearing event.
// The clear window is judged on the combined prescaler and postscaler
// count, so it also works with a postscale ratio of 1:1.
// An early-clear reset does not set the timeout flag; only a real
// expiry does, in run mode and in power save alike.
// The configuration word is writable to stand in for programming;
// software is expected to write it once, before enabling.
// Result pulses are registered and last one cycle each.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module wdt_top (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Avalon-MM slave
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // Core events and status
  input  wire wdt_pkg::wdt_events_t core_events,
  output wdt_pkg::wdt_result_t     wdt_result,
  output logic                     low_power_rc_enable
);

  logic [7:0]  cfg_q;
  logic        soft_en_q;
  logic        timeout_flag_q;
  logic        sleep_flag_q;
  logic        idle_flag_q;
  logic [9:0]  rc_div_q;
  logic        rc_tick;
  logic [6:0]  pre_q;
  logic        pre_tick;
  logic [14:0] post_q;
  logic [14:0] post_top;
  logic        wdt_enable;
  logic        clear_all;
  logic        expire;
  logic        early_clear;
  logic        in_window;
  logic        bus_ack_q;
  logic        rd_ok;
  logic        wr_rc;
  logic        wr_cfg;
  logic        reset_req_q;
  logic        wake_q;
  logic [3:0]  post_sel;
  logic [4:0]  win_shift;
  logic [22:0] win_span;
  logic [22:0] win_start;
  logic [22:0] win_count;
  logic [5:0]  rc_view;
  wdt_pkg::wdt_mode_t mode_q;

  // Enable: hard bit forces on, else software bit
  assign wdt_enable = cfg_q[wdt_pkg::CFG_HARD_BIT] | soft_en_q;
  assign low_power_rc_enable = wdt_enable;
  assign post_sel = cfg_q[wdt_pkg::CFG_POST_LSB +: 4];

  // Reset control view, low byte only
  assign rc_view = {soft_en_q, timeout_flag_q, sleep_flag_q, idle_flag_q, 2'b00};

  // Postscaler terminal count per code; each step down halves the ratio
  always_comb begin
    case (post_sel)
      4'h0: post_top = 15'h0000;
      4'h1: post_top = 15'h0001;
      4'h2: post_top = 15'h0003;
      4'h3: post_top = 15'h0007;
      4'h4: post_top = 15'h000f;
      4'h5: post_top = 15'h001f;
      4'h6: post_top = 15'h003f;
      4'h7: post_top = 15'h007f;
      4'h8: post_top = 15'h00ff;
      4'h9: post_top = 15'h01ff;
      4'ha: post_top = 15'h03ff;
      4'hb: post_top = 15'h07ff;
      4'hc: post_top = 15'h0fff;
      4'hd: post_top = 15'h1fff;
      4'he: post_top = 15'h3fff;
      default: post_top = 15'h7fff;  // Largest ratio, 1:32768
    endcase
  end

  // Any clearing event restarts all three counters
  assign clear_all = core_events.clock_switch_done
                   | core_events.clear_instr
                   | core_events.enter_sleep
                   | core_events.enter_idle
                   | core_events.exit_power_save
                   | ~wdt_enable;

  // Window: final quarter of the whole period, prescaler and postscaler together
  assign win_shift = 5'(post_sel) + (cfg_q[wdt_pkg::CFG_PRE_BIT] ? 5'($clog2(wdt_pkg::PRE_DIV_128))
                                                               : 5'($clog2(wdt_pkg::PRE_DIV_32)));
  assign win_span  = 23'h00_0001 << win_shift;
  assign win_start = win_span - (win_span >> 2);
  // Counts below the span, so no overflow at the largest ratio
  assign win_count = cfg_q[wdt_pkg::CFG_PRE_BIT] ? {1'b0, post_q, pre_q}
                                                 : {3'b000, post_q, pre_q[4:0]};
  assign in_window = (win_count >= win_start);
  assign early_clear = core_events.clear_instr & wdt_enable & ~cfg_q[wdt_pkg::CFG_WIN_BIT]
                     & (mode_q == wdt_pkg::WDT_RUN) & ~in_window;

  // Bus decode: one wait cycle, then acknowledge
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_q;
  assign wr_rc  = avs_write & bus_ack_q & (avs_address == wdt_pkg::OFS_RESET_CTRL) & avs_byteenable[0];
  assign wr_cfg = avs_write & bus_ack_q & (avs_address == wdt_pkg::OFS_CONFIG) & avs_byteenable[0];
  assign rd_ok  = avs_read & ~bus_ack_q;

  // Acknowledge toggles so each request gets one wait state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_ack_q <= 1'b0;
    end else begin
      bus_ack_q <= (avs_read | avs_write) & ~bus_ack_q;
    end
  end

  // Read data registered during the wait cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_ok) begin
      if (avs_address == wdt_pkg::OFS_RESET_CTRL) begin
        avs_readdata <= {26'h000_0000, rc_view};
      end else if (avs_address == wdt_pkg::OFS_CONFIG) begin
        avs_readdata <= {24'h00_0000, cfg_q};
      end else if (avs_address == wdt_pkg::OFS_STATUS) begin
        avs_readdata <= {17'h0_0000, post_q};
      end else begin
        avs_readdata <= 32'h0000_0000;  // Unmapped reads zero
      end
    end
  end

  // Configuration word, write-once style: writable, reset to defaults
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= wdt_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= avs_writedata[7:0];
    end
  end

  // Software enable, cleared by any device reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      soft_en_q <= 1'b0;
    end else if (wdt_result.device_reset) begin
      soft_en_q <= 1'b0;
    end else if (wr_rc) begin
      soft_en_q <= avs_writedata[wdt_pkg::RC_SOFT_EN_BIT];
    end
  end

  // Sticky timeout flag; a new timeout beats a software clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timeout_flag_q <= 1'b0;
    end else if (expire) begin
      timeout_flag_q <= 1'b1;
    end else if (wr_rc && !avs_writedata[wdt_pkg::RC_TIMEOUT_BIT]) begin
      timeout_flag_q <= 1'b0;
    end
  end

  // Sleep status: set on entry, never cleared by a wake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_flag_q <= 1'b0;
    end else if (core_events.enter_sleep) begin
      sleep_flag_q <= 1'b1;
    end else if (wr_rc && !avs_writedata[wdt_pkg::RC_SLEEP_BIT]) begin
      sleep_flag_q <= 1'b0;
    end
  end

  // Idle status: set on entry, never cleared by a wake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_flag_q <= 1'b0;
    end else if (core_events.enter_idle) begin
      idle_flag_q <= 1'b1;
    end else if (wr_rc && !avs_writedata[wdt_pkg::RC_IDLE_BIT]) begin
      idle_flag_q <= 1'b0;
    end
  end

  // Power mode tracking; a wake from timeout returns to run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= wdt_pkg::WDT_RUN;
    end else begin
      case (mode_q)
        wdt_pkg::WDT_RUN: begin
          if (core_events.enter_sleep) begin
            mode_q <= wdt_pkg::WDT_SLEEP;
          end else if (core_events.enter_idle) begin
            mode_q <= wdt_pkg::WDT_IDLE;
          end
        end
        wdt_pkg::WDT_SLEEP, wdt_pkg::WDT_IDLE: begin
          if (core_events.exit_power_save || expire) begin
            mode_q <= wdt_pkg::WDT_RUN;
          end
        end
        default: begin
          mode_q <= wdt_pkg::WDT_RUN;
        end
      endcase
    end
  end

  // RC clock model: tick enable at the nominal 32 kHz
  // Restarts with the counters so the timeout is a fixed count after a clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rc_div_q <= 10'h000;
    end else if (clear_all || wdt_result.device_reset) begin
      rc_div_q <= 10'h000;
    end else if (rc_div_q == 10'(wdt_pkg::RC_DIV - 1)) begin
      rc_div_q <= 10'h000;
    end else begin
      rc_div_q <= rc_div_q + 10'h001;
    end
  end
  assign rc_tick = wdt_enable & (rc_div_q == 10'(wdt_pkg::RC_DIV - 1));

  // Prescaler, divide by 32 or 128 per prescale bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 7'h00;
    end else if (clear_all || wdt_result.device_reset) begin
      pre_q <= 7'h00;
    end else if (rc_tick) begin
      pre_q <= pre_tick ? 7'h00 : pre_q + 7'h01;
    end
  end
  assign pre_tick = rc_tick & (cfg_q[wdt_pkg::CFG_PRE_BIT]
                    ? (pre_q == 7'(wdt_pkg::PRE_DIV_128 - 1))
                    : (pre_q == 7'(wdt_pkg::PRE_DIV_32 - 1)));

  // Postscaler and timeout detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      post_q <= 15'h0000;
    end else if (clear_all || wdt_result.device_reset) begin
      post_q <= 15'h0000;
    end else if (pre_tick) begin
      post_q <= (post_q == post_top) ? 15'h0000 : post_q + 15'h0001;
    end
  end
  assign expire = pre_tick & (post_q == post_top) & ~clear_all;

  // Reset request: timeout or early clear in window mode, both only while running
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= (expire & (mode_q == wdt_pkg::WDT_RUN)) | early_clear;
    end
  end

  // Wake request: timeout in power save resumes, never resets
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= expire & (mode_q != wdt_pkg::WDT_RUN);
    end
  end
  assign wdt_result.device_reset = reset_req_q;
  assign wdt_result.wake         = wake_q;

endmodule // wdt_top

// file: bench/wdt_checker.sv
// Port-level timing checks for the watchdog block
`timescale 1ns/1ps
module wdt_checker (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 resetn,
  // Register bus
  input wire logic [3:0]           avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  // Watchdog outcome
  input wire wdt_pkg::wdt_result_t wdt_result,
  input wire logic                 low_power_rc_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Bus: one wait state, then the answer
  wait_first_a: assert property ((avs_read || avs_write) && !$past(avs_read) && !$past(avs_write) |-> avs_waitrequest)
    else $error("new request not held off");
  ack_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && !(avs_address inside {4'h0, 4'h4, 4'h8})
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
  // Outcome pulses last one cycle and come only from a running watchdog
  reset_pulse_a: assert property (wdt_result.device_reset |=> !wdt_result.device_reset)
    else $error("device reset longer than one cycle");
  wake_only_a: assert property (wdt_result.wake |-> !wdt_result.device_reset ##1 !wdt_result.wake)
    else $error("wake pulse wrong");
  wake_enabled_a: assert property (wdt_result.wake |-> $past(low_power_rc_enable))
    else $error("wake while disabled");
  reset_enabled_a: assert property (wdt_result.device_reset |-> $past(low_power_rc_enable))
    else $error("device reset while clock off");
  cover property (wdt_result.wake);
  cover property (wdt_result.device_reset);
  cover property (avs_read && !avs_waitrequest);
endmodule // wdt_checker

// file: bench/tb.sv
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
module tb;
  localparam int P = wdt_pkg::RC_DIV * wdt_pkg::PRE_DIV_32;
  localparam wdt_pkg::wdt_events_t EV_CLR = '{clear_instr: 1'b1, default: 1'b0};
  localparam wdt_pkg::wdt_events_t EV_SLP = '{enter_sleep: 1'b1, default: 1'b0};
  localparam wdt_pkg::wdt_events_t EV_CSW = '{clock_switch_done: 1'b1, default: 1'b0};
  logic                 clk           = 1'b0;
  logic                 resetn        = 1'b0;
  logic [3:0]           avs_address   = 4'h0;
  logic                 avs_read      = 1'b0;
  logic                 avs_write     = 1'b0;
  logic [31:0]          avs_writedata = 32'h0000_0000;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  wdt_pkg::wdt_events_t core_events   = '0;
  wdt_pkg::wdt_result_t wdt_result;
  logic                 low_power_rc_enable;
  logic [31:0]          rd;
  int                   n;
  int                   miscompares   = 0;
  int                   total_checks  = 0;
  int                   cycles        = 0;
  // Design under test; byte lane 0 always enabled
  wdt_top i_wdt_top (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_events(core_events), .wdt_result(wdt_result),
    .low_power_rc_enable(low_power_rc_enable));
  // Clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bus cycle held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input wdt_pkg::wdt_events_t e);
    core_events <= e;
    @(posedge clk);
    core_events <= '0;
  endtask
  // Waits for an outcome pulse, bounded, and checks kind and delay
  task automatic wait_res(input logic [1:0] exp, input int lo, input int hi);
    n = 0;
    while (wdt_result === 2'b00 && n < hi + 8) begin
      @(posedge clk);
      n++;
    end
    chk(wdt_result, exp);
    chk(n >= lo && n <= hi, 1);
  endtask
  task automatic t_reset_values;
    bus(0, wdt_pkg::OFS_CONFIG, 0);
    chk(rd, 32'(wdt_pkg::CFG_RESET));
    bus(0, wdt_pkg::OFS_RESET_CTRL, 0);
    chk(rd, 0);
    chk(low_power_rc_enable, 1);
    bus(0, 4'hc, 0);
    chk(rd, 0);
  endtask
  task automatic t_window_early;
    bus(1, wdt_pkg::OFS_CONFIG, 32'h0000_0000);
    chk(low_power_rc_enable, 0);
    bus(1, wdt_pkg::OFS_RESET_CTRL, 32'h0000_0020);
    chk(low_power_rc_enable, 1);
    pulse(EV_CLR);
    wait_res(2'b10, 0, 3);
    bus(0, wdt_pkg::OFS_RESET_CTRL, 0);
    chk(rd, 0);
    bus(1, wdt_pkg::OFS_RESET_CTRL, 32'h0000_0020);
    repeat (P * 7 / 8) @(posedge clk);
    pulse(EV_CLR);
    repeat (4) begin
      @(posedge clk);
      chk(wdt_result, 2'b00);
    end
    bus(1, wdt_pkg::OFS_RESET_CTRL, 0);
  endtask
  task automatic t_run_timeout;
    bus(1, wdt_pkg::OFS_CONFIG, 32'h0000_0040);
    bus(1, wdt_pkg::OFS_RESET_CTRL, 32'h0000_0020);
    pulse(EV_CLR);
    repeat (P / 2) @(posedge clk);
    pulse(EV_CSW);
    wait_res(2'b10, P - 1, P + 2);
    bus(0, wdt_pkg::OFS_RESET_CTRL, 0);
    chk(rd, 32'h0000_0010);
    bus(1, wdt_pkg::OFS_RESET_CTRL, 0);
    bus(0, wdt_pkg::OFS_RESET_CTRL, 0);
    chk(rd, 0);
  endtask
  task automatic t_sleep_wake;
    bus(1, wdt_pkg::OFS_RESET_CTRL, 32'h0000_0020);
    pulse(EV_SLP);
    wait_res(2'b01, P - 1, P + 2);
    bus(0, wdt_pkg::OFS_RESET_CTRL, 0);
    chk(rd, 32'h0000_0038);
    bus(1, wdt_pkg::OFS_RESET_CTRL, 32'h0000_0020);
    bus(0, wdt_pkg::OFS_RESET_CTRL, 0);
    chk(rd, 32'h0000_0020);
    bus(1, wdt_pkg::OFS_RESET_CTRL, 0);
  endtask
  task automatic finish_test;
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard, above the four long waits together
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset_values();
    t_window_early();
    t_run_timeout();
    t_sleep_wake();
    finish_test();
  end
endmodule // tb
bind wdt_top wdt_checker i_wdt_checker (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wdt_result(wdt_result),
  .low_power_rc_enable(low_power_rc_enable));
